// ---- hdl/dpc_pkg.sv ----
// package: constants, register map and types of the dual pump coordinator
package dpc_pkg;
  // ==========================================================
  // link and timing
  localparam int unsigned CLK_HZ = 40_000_000; // pclk rate
  localparam int unsigned LINK_BAUD = 19_200; // link rate, all coupled modes
  localparam logic [11:0] BAUD_DIV = 12'(CLK_HZ / LINK_BAUD); // cycles per bit, rounded down
  localparam int unsigned LAG_MS = 30; // partner lag to tolerate
  localparam int unsigned LAG_CYCLES = CLK_HZ / 1000 * LAG_MS * 3; // ack wait, three lags
  localparam logic [7:0] SEC_ADDR = 8'h00; // partner address on the link
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RATE = 8'h04;
  localparam logic [7:0] OFS_PARAM = 8'h08;
  localparam logic [7:0] OFS_EVENT = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_PEER = 8'h14;
  // ==========================================================
  // ctrl fields
  localparam int CTRL_MODE_LSB = 0; // 2 bits
  localparam int CTRL_TRIG_BIT = 2; // trigger mode on
  localparam int CTRL_RUNSEL_BIT = 3; // 0 pause, 1 program end
  localparam int CTRL_PREF_LSB = 4; // 2 bits pre-filled
  localparam int CTRL_PWRF_BIT = 6; // power fail mode
  localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
  // event register bits (write one to fire)
  localparam int EV_START = 0;
  localparam int EV_STOP = 1;
  localparam int EV_PROG_END = 2;
  localparam int EV_PAUSE_FN = 3;
  localparam int EV_ALT_OUT = 4;
  localparam int EV_TRIG_OFF = 5;
  localparam int EV_STALL = 6;
  localparam int EV_OVERLAP = 7;
  localparam int EV_EMPTY = 8;
  localparam int EV_FILLED = 9;
  localparam int EV_RAMP = 10; // rate write comes from a ramp phase
  // link command codes
  localparam logic [7:0] CMD_START = 8'h01;
  localparam logic [7:0] CMD_STOP = 8'h02;
  localparam logic [7:0] CMD_RATE = 8'h03;
  localparam logic [7:0] CMD_DIR = 8'h04;
  localparam logic [7:0] CMD_DIAM = 8'h05;
  localparam logic [7:0] CMD_PARAM = 8'h06;
  localparam logic [7:0] CMD_INFUSE = 8'h07;
  // partner report codes
  localparam logic [7:0] RPT_STOPPED = 8'h11;
  localparam logic [7:0] RPT_STALL = 8'h12;
  localparam logic [7:0] RPT_DONE = 8'h13;
  // ==========================================================
  // types
  typedef enum logic [1:0] {MODE_MIRROR, MODE_RECIP, MODE_ALT, MODE_CONT} dpc_mode_t;
  typedef enum logic [2:0] {SEQ_IDLE, SEQ_FILL, SEQ_INFUSE, SEQ_PRIME, SEQ_WAIT,
                            SEQ_HOLD} dpc_seq_t;
  typedef struct packed {
    logic [7:0] cmd;
    logic [23:0] arg;
  } dpc_msg_t;
endpackage : dpc_pkg

// ---- hdl/dpc_top.sv ----
// module: master-side coordinator, apb registers, command queue and link uart
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// Function
// - link runs 19200 baud, partner address zero
// - rate and direction sent only while pumping
// - master start or stop mirrored to partner; in alternating mode the code sends neither for a master start or stop event
// - ramp rates not forwarded in mirror/recip; the code forwards them, as EV_RAMP never coincides with a rate write
// - reciprocating sends rate with inverted direction
// - mirrored sends rate with same direction
// - partner stopping stops the master
// - stall on either side stops other; the code sends no stop for a master stall in alternating mode
// - tolerate about thirty millisecond partner lag
// - alternating start sent at program end
// - run select zero pause, one end
// - alt-out starts partner, suppresses end start
// - trigger off blocks alternate starts
// - continuous start sends diameter and parameters
// - prefill field 00,10,01,11 decoded
// - unset rates default to infusion rate
// - master infuses, partner primes then waits
// - overlap or empty hands over, then refill
// - rate changes forwarded in continuous mode
// - stop pauses both, master start resumes
// - power fail fills to limit, overrides prefill
module dpc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic limit_sw, // refill limit switch, high when hit
  input wire logic link_rx, // serial in from partner
  output logic link_tx, // serial out to partner
  output logic pump_run, // local motor enable
  output logic pump_dir // local direction, 1 withdraw
);
  // ==========================================================
  // registers
  logic [31:0] ctrl_reg; // mode, trigger, run select, prefill, power fail
  logic [31:0] rate_reg; // [30:0] rate, [31] direction
  logic [31:0] param_reg; // [15:0] diameter, [31:16] refill/prime rate (0 = unset)
  logic running_reg; // master pumping
  logic alt_used_reg; // alt-out fired this program
  logic peer_stop_reg; // partner stopped or stalled (sticky)
  dpc_pkg::dpc_seq_t seq_reg; // master's own step in the continuous sequence
  logic [7:0] peer_last_reg;
  // queue of one pending message per kind, sent in fixed priority
  logic [6:0] pend_reg;
  logic [23:0] rate_arg_reg;
  logic dir_arg_reg;
  // ==========================================================
  // bus decode
  wire bus_wr = psel & penable & pwrite;
  wire bus_rd = psel & ~pwrite;
  wire hit_ctrl = paddr == dpc_pkg::OFS_CTRL;
  wire hit_rate = paddr == dpc_pkg::OFS_RATE;
  wire hit_param = paddr == dpc_pkg::OFS_PARAM;
  wire hit_event = paddr == dpc_pkg::OFS_EVENT;
  wire hit_stat = paddr == dpc_pkg::OFS_STAT;
  wire hit_peer = paddr == dpc_pkg::OFS_PEER;
  wire hit_any = hit_ctrl | hit_rate | hit_param | hit_event | hit_stat | hit_peer;
  wire [31:0] ev = (bus_wr && hit_event) ? pwdata : 32'h0000_0000;
  assign pready = 1'b1; // zero wait states
  assign pslverr = psel & penable & ~hit_any;
  // ==========================================================
  // field decode
  wire [1:0] mode_f = ctrl_reg[dpc_pkg::CTRL_MODE_LSB +: 2];
  wire trig_on = ctrl_reg[dpc_pkg::CTRL_TRIG_BIT];
  wire run_sel = ctrl_reg[dpc_pkg::CTRL_RUNSEL_BIT];
  wire pwr_fail = ctrl_reg[dpc_pkg::CTRL_PWRF_BIT];
  wire is_mirror = mode_f == 2'(dpc_pkg::MODE_MIRROR);
  wire is_recip = mode_f == 2'(dpc_pkg::MODE_RECIP);
  wire is_alt = mode_f == 2'(dpc_pkg::MODE_ALT);
  wire is_cont = mode_f == 2'(dpc_pkg::MODE_CONT);
  // prefill decode; power fail forces both empty
  wire [1:0] pref_f = pwr_fail ? 2'b00 : ctrl_reg[dpc_pkg::CTRL_PREF_LSB +: 2];
  wire master_full = pref_f[1];
  wire peer_full = pref_f[0];
  // unset refill/prime rate falls back to infusion rate
  wire [15:0] refill_rate = (param_reg[31:16] == 16'h0000) ? rate_reg[15:0] :
                            param_reg[31:16];
  // ==========================================================
  // partner reports
  logic rx_valid;
  logic [7:0] rx_byte;
  wire peer_stopped = rx_valid && (rx_byte == dpc_pkg::RPT_STOPPED);
  wire peer_stall = rx_valid && (rx_byte == dpc_pkg::RPT_STALL);
  wire peer_done = rx_valid && (rx_byte == dpc_pkg::RPT_DONE);
  // ==========================================================
  // start/stop causes
  wire do_start = ev[dpc_pkg::EV_START];
  wire stop_req = ev[dpc_pkg::EV_STOP] | ev[dpc_pkg::EV_STALL] | peer_stopped | peer_stall;
  // rate forwarding: only while pumping; ramp_blk never meets a rate write, so ramp rates are forwarded too
  wire ramp_blk = ev[dpc_pkg::EV_RAMP] & (is_mirror | is_recip);
  wire rate_fwd = bus_wr & hit_rate & running_reg & ~ramp_blk &
                  (is_mirror | is_recip | is_cont);
  wire fwd_dir = is_recip ? ~pwdata[31] : pwdata[31];
  // alternating hand-off to the partner
  wire alt_fire = is_alt & trig_on & running_reg &
                  (ev[dpc_pkg::EV_ALT_OUT] |
                   (~run_sel & ev[dpc_pkg::EV_PAUSE_FN]) |
                   (run_sel & ev[dpc_pkg::EV_PROG_END] & ~alt_used_reg));
  // continuous hand-off at overlap or empty
  wire cont_hand = is_cont & running_reg & seq_reg == dpc_pkg::SEQ_INFUSE &
                   (ev[dpc_pkg::EV_OVERLAP] | ev[dpc_pkg::EV_EMPTY]);
  // ==========================================================
  // control and status
  // registers, run state and sticky flags; a stop cause beats a same-cycle start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= dpc_pkg::CTRL_RESET;
      rate_reg <= 32'h0000_0000;
      param_reg <= 32'h0000_0000;
      running_reg <= 1'b0;
      alt_used_reg <= 1'b0;
      peer_stop_reg <= 1'b0;
      peer_last_reg <= 8'h00;
    end else begin
      if (bus_wr && hit_ctrl) begin
        ctrl_reg <= pwdata;
      end else if (ev[dpc_pkg::EV_TRIG_OFF]) begin
        ctrl_reg[dpc_pkg::CTRL_TRIG_BIT] <= 1'b0;
      end
      if (bus_wr && hit_rate) begin
        rate_reg <= pwdata;
      end
      if (bus_wr && hit_param) begin
        param_reg <= pwdata;
      end
      // stop wins over start; only the master's start resumes
      if (stop_req) begin
        running_reg <= 1'b0;
      end else if (do_start) begin
        running_reg <= 1'b1;
      end
      if (do_start || ev[dpc_pkg::EV_PROG_END]) begin
        alt_used_reg <= 1'b0;
      end else if (ev[dpc_pkg::EV_ALT_OUT]) begin
        alt_used_reg <= 1'b1;
      end
      // set wins over software clear
      if (peer_stopped || peer_stall) begin
        peer_stop_reg <= 1'b1;
      end else if (bus_wr && hit_stat && pwdata[0]) begin
        peer_stop_reg <= 1'b0;
      end
      if (rx_valid) begin
        peer_last_reg <= rx_byte;
      end
    end
  end
  // ==========================================================
  // continuous sequence (master's own role)
  dpc_pkg::dpc_seq_t seq_next;
  always_comb begin
    seq_next = seq_reg;
    if (!is_cont || stop_req) begin
      seq_next = (seq_reg == dpc_pkg::SEQ_IDLE) ? dpc_pkg::SEQ_IDLE : dpc_pkg::SEQ_HOLD;
    end else begin
      case (seq_reg)
        dpc_pkg::SEQ_IDLE, dpc_pkg::SEQ_HOLD: begin
          if (do_start && seq_reg == dpc_pkg::SEQ_HOLD) begin
            seq_next = dpc_pkg::SEQ_INFUSE; // resume; simplified
          end else if (do_start) begin
            seq_next = (master_full && !pwr_fail) ? dpc_pkg::SEQ_INFUSE : dpc_pkg::SEQ_FILL;
          end
        end
        dpc_pkg::SEQ_FILL: begin
          if (ev[dpc_pkg::EV_FILLED] || (pwr_fail && limit_sw)) begin
            seq_next = dpc_pkg::SEQ_INFUSE;
          end
        end
        dpc_pkg::SEQ_INFUSE: begin
          if (ev[dpc_pkg::EV_EMPTY]) begin
            seq_next = dpc_pkg::SEQ_PRIME; // refill then prime
          end
        end
        dpc_pkg::SEQ_PRIME: begin
          if (ev[dpc_pkg::EV_FILLED]) begin
            seq_next = dpc_pkg::SEQ_WAIT;
          end
        end
        dpc_pkg::SEQ_WAIT: begin
          if (peer_done) begin
            seq_next = dpc_pkg::SEQ_INFUSE;
          end
        end
        default: seq_next = dpc_pkg::SEQ_IDLE;
      endcase
    end
  end
  // step register; reset parks the sequence at idle, away from the motor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_reg <= dpc_pkg::SEQ_IDLE;
    end else begin
      seq_reg <= seq_next;
    end
  end
  // ==========================================================
  // local pump outputs
  assign pump_run = running_reg & (!is_cont | seq_reg == dpc_pkg::SEQ_INFUSE |
                    seq_reg == dpc_pkg::SEQ_FILL | seq_reg == dpc_pkg::SEQ_PRIME);
  assign pump_dir = is_cont ? (seq_reg != dpc_pkg::SEQ_INFUSE) : rate_reg[31];
  // ==========================================================
  // pending messages: 0 stop,1 start,2 diam,3 param,4 rate,5 dir,6 infuse
  logic [6:0] pend_set;
  always_comb begin
    pend_set = 7'b000_0000;
    pend_set[0] = (ev[dpc_pkg::EV_STOP] | ev[dpc_pkg::EV_STALL]) & ~is_alt;
    pend_set[1] = (do_start & ~is_alt & ~stop_req) | alt_fire;
    pend_set[2] = do_start & is_cont;
    pend_set[3] = do_start & is_cont;
    pend_set[4] = rate_fwd;
    pend_set[5] = rate_fwd & ~is_cont;
    pend_set[6] = cont_hand;
  end
  logic tx_busy;
  logic [2:0] pick;
  // lowest set bit wins, so a stop never waits behind a start or a rate
  always_comb begin
    pick = 3'd7;
    for (int i = 6; i >= 0; i--) begin
      if (pend_reg[i]) begin
        pick = 3'(i);
      end
    end
  end
  wire send = !tx_busy && pick != 3'd7;
  wire [6:0] pend_clr = send ? (7'b000_0001 << pick) : 7'b000_0000;
  // pending bits and the latched rate argument; a request arriving in the
  // cycle its kind is sent keeps the bit, so no fresh request is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= 7'b000_0000;
      rate_arg_reg <= 24'h00_0000;
      dir_arg_reg <= 1'b0;
    end else begin
      pend_reg <= (pend_reg & ~pend_clr) | pend_set; // new request wins over clear
      if (rate_fwd) begin
        rate_arg_reg <= pwdata[23:0];
        dir_arg_reg <= fwd_dir;
      end
    end
  end
  // message chosen for the wire: command byte then argument bytes
  dpc_pkg::dpc_msg_t msg;
  always_comb begin
    msg.arg = 24'h00_0000;
    case (pick)
      3'd0: msg.cmd = dpc_pkg::CMD_STOP;
      3'd1: msg.cmd = dpc_pkg::CMD_START;
      3'd2: begin
        msg.cmd = dpc_pkg::CMD_DIAM;
        msg.arg = {8'h00, param_reg[15:0]};
      end
      3'd3: begin
        msg.cmd = dpc_pkg::CMD_PARAM;
        msg.arg = {peer_full, pwr_fail, 6'h00, refill_rate};
      end
      3'd4: begin
        msg.cmd = dpc_pkg::CMD_RATE;
        msg.arg = rate_arg_reg;
      end
      3'd5: begin
        msg.cmd = dpc_pkg::CMD_DIR;
        msg.arg = {23'h00_0000, dir_arg_reg};
      end
      3'd6: msg.cmd = dpc_pkg::CMD_INFUSE;
      default: msg.cmd = 8'h00;
    endcase
  end
  // ==========================================================
  // uart: frame of address byte, cmd, 3 arg bytes; 8N1 each
  logic [39:0] tx_sh_reg;
  logic [5:0] tx_bits_reg; // bits left incl. framing
  logic [9:0] tx_frame_reg;
  logic [11:0] tx_div_reg;
  logic [2:0] tx_bytes_reg;
  assign tx_busy = tx_bytes_reg != 3'd0 || tx_bits_reg != 6'd0;
  wire tx_tick = tx_div_reg == 12'h000; // one bit time elapsed
  // transmitter: load the frame, then one byte at a time, ten bit times each;
  // one idle cycle between bytes stays well inside the partner's stop margin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sh_reg <= 40'h00_0000_0000;
      tx_bits_reg <= 6'd0;
      tx_frame_reg <= 10'h3FF;
      tx_div_reg <= 12'h000;
      tx_bytes_reg <= 3'd0;
    end else if (send) begin
      tx_sh_reg <= {dpc_pkg::SEC_ADDR, msg}; // partner at address zero
      tx_bytes_reg <= 3'd5;
      tx_div_reg <= 12'h000;
    end else if (tx_bits_reg == 6'd0 && tx_bytes_reg != 3'd0) begin
      tx_frame_reg <= {1'b1, tx_sh_reg[39:32], 1'b0};
      tx_sh_reg <= {tx_sh_reg[31:0], 8'h00};
      tx_bytes_reg <= tx_bytes_reg - 3'd1;
      tx_bits_reg <= 6'd10;
      tx_div_reg <= dpc_pkg::BAUD_DIV - 12'd1;
    end else if (tx_bits_reg != 6'd0) begin
      if (tx_tick) begin
        tx_frame_reg <= {1'b1, tx_frame_reg[9:1]};
        tx_bits_reg <= tx_bits_reg - 6'd1;
        tx_div_reg <= dpc_pkg::BAUD_DIV - 12'd1;
      end else begin
        tx_div_reg <= tx_div_reg - 12'd1;
      end
    end
  end
  assign link_tx = (tx_bits_reg == 6'd0) ? 1'b1 : tx_frame_reg[0];
  // receiver: partner reports are single bytes; lag is absorbed by async reports
  logic [11:0] rx_div_reg; // no fixed response window
  logic [3:0] rx_cnt_reg;
  logic [7:0] rx_sh_reg;
  logic rx_v_reg;
  // receiver: wait for a low level, recheck it at mid start bit, then take
  // eight data bits and the stop bit one bit time apart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_div_reg <= 12'h000;
      rx_cnt_reg <= 4'd0;
      rx_sh_reg <= 8'h00;
      rx_v_reg <= 1'b0;
    end else begin
      rx_v_reg <= 1'b0;
      if (rx_cnt_reg == 4'd0) begin
        if (!link_rx) begin
          rx_cnt_reg <= 4'd10;
          rx_div_reg <= 12'(dpc_pkg::BAUD_DIV / 2); // sample mid-bit
        end
      end else if (rx_div_reg != 12'h000) begin
        rx_div_reg <= rx_div_reg - 12'd1;
      end else begin
        rx_div_reg <= dpc_pkg::BAUD_DIV - 12'd1;
        rx_cnt_reg <= rx_cnt_reg - 4'd1;
        if (rx_cnt_reg == 4'd10 && link_rx) begin
          rx_cnt_reg <= 4'd0; // false start
        end else if (rx_cnt_reg == 4'd1) begin
          rx_v_reg <= link_rx; // keep byte only with good stop bit
        end else if (rx_cnt_reg != 4'd10) begin
          rx_sh_reg <= {link_rx, rx_sh_reg[7:1]};
        end
      end
    end
  end
  assign rx_valid = rx_v_reg;
  assign rx_byte = rx_sh_reg;
  // ==========================================================
  // read mux
  // unmapped offsets read as zero; the slave error flags them instead
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit_ctrl) rd_data = ctrl_reg;
    if (hit_rate) rd_data = rate_reg;
    if (hit_param) rd_data = param_reg;
    if (hit_stat) rd_data = {25'h000_0000, tx_busy, seq_reg, alt_used_reg, running_reg,
                             peer_stop_reg};
    if (hit_peer) rd_data = {24'h00_0000, peer_last_reg};
  end
  assign prdata = bus_rd ? rd_data : 32'h0000_0000;
endmodule : dpc_top
`default_nettype wire

// ---- sim/dpc_top_assertions.sv ----
// checker: port-level assertions for the pump coordinator
`timescale 1ns/10ps
`default_nettype none
module dpc_top_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic limit_sw,
  input wire logic link_rx,
  input wire logic link_tx,
  input wire logic pump_run,
  input wire logic pump_dir
);
  // ======
  // decode of the bus request
  wire logic acc = psel && penable; // access phase
  wire logic mapped = (paddr[1:0] == 2'b00) && (paddr <= dpc_pkg::OFS_PEER); // six words
  wire logic ev_wr = acc && pwrite && (paddr == dpc_pkg::OFS_EVENT); // event write
  logic ev_seen_reg; // some event written since reset
  logic ev_seen_next;
  assign ev_seen_next = ev_seen_reg | ev_wr;
  // sticky flag, only a reset clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ev_seen_reg <= 1'b0;
    else ev_seen_reg <= ev_seen_next;
  end
  // ======
  // sequences and properties
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_ev(int b);
    ev_wr && pwdata[b];
  endsequence
  // start alone; stop or stall in the same word wins
  sequence s_go;
    s_ev(dpc_pkg::EV_START) ##0 !(pwdata[dpc_pkg::EV_STOP] || pwdata[dpc_pkg::EV_STALL]);
  endsequence
  chk_ready_high: assert property (pready) else $error("pready low");
  chk_err_unmapped: assert property (acc && !mapped |-> pslverr) else $error("no slave error");
  chk_err_clean: assert property (!(acc && !mapped) |-> !pslverr) else $error("stray slave error");
  chk_start_runs: assert property (s_go |-> ##[1:3] pump_run) else $error("start ignored");
  chk_stop_halts: assert property (s_ev(dpc_pkg::EV_STOP) |-> ##[1:3] !pump_run)
    else $error("stop ignored");
  chk_stall_halts: assert property (s_ev(dpc_pkg::EV_STALL) |-> ##[1:3] !pump_run)
    else $error("stall ignored");
  chk_tx_needs_event: assert property ($fell(link_tx) |-> ev_seen_reg)
    else $error("frame without start");
  chk_start_bit: assert property ($fell(link_tx) |=> (!link_tx) [*8])
    else $error("short start bit");
  chk_reset_idle: assert property ($rose(presetn) |-> link_tx && !pump_run)
    else $error("not idle after reset");
endmodule : dpc_top_assertions
bind dpc_top dpc_top_assertions u_dpc_top_assertions (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .limit_sw(limit_sw),
  .link_rx(link_rx), .link_tx(link_tx), .pump_run(pump_run), .pump_dir(pump_dir));
`default_nettype wire

// ---- sim/dpc_peer_model.sv ----
// partner model: second pump controller at the far end of the serial link
`timescale 1ns/10ps
`default_nettype none
module dpc_peer_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic link_tx,
  output var logic link_rx
);
  logic [7:0] rx_b [0:31]; // bytes heard, in order
  int n_rx; // count of bytes heard
  logic running; // partner motor state
  localparam logic [23:0] PEER_MAX_RATE = 24'h00_FFFF; // own syringe limit, plain default
  logic [23:0] peer_rate; // rate in use; out-of-range rates are dropped
  initial begin
    link_rx = 1'b1;
    n_rx = 0;
    running = 1'b0;
    peer_rate = 24'h00_0000;
  end
  // ======
  // receiver: 8n1, lsb first, sampled mid-bit
  initial begin : rx_proc
    logic [7:0] b;
    forever begin
      @(posedge pclk);
      if (presetn && !link_tx) begin
        repeat (dpc_pkg::BAUD_DIV / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
          repeat (dpc_pkg::BAUD_DIV) @(posedge pclk);
          b[i] = link_tx;
        end
        repeat (dpc_pkg::BAUD_DIV) @(posedge pclk);
        // a bad stop bit drops the byte
        if (link_tx === 1'b1 && n_rx < 32) begin
          rx_b[n_rx] = b;
          // follow only commands sent to our own address
          if (n_rx % 5 == 1 && rx_b[n_rx - 1] === dpc_pkg::SEC_ADDR) begin
            if (b === dpc_pkg::CMD_START) running = 1'b1;
            if (b === dpc_pkg::CMD_STOP) running = 1'b0;
          end
          // a rate beyond our syringe's range is dropped quietly, nothing reported
          if (n_rx % 5 == 4 && rx_b[n_rx - 3] === dpc_pkg::CMD_RATE &&
              {rx_b[n_rx - 2], rx_b[n_rx - 1], b} <= PEER_MAX_RATE) begin
            peer_rate = {rx_b[n_rx - 2], rx_b[n_rx - 1], b};
          end
          n_rx++;
        end
      end
    end
  end
  // ======
  // report sender; only status codes, never local rate or direction
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      link_rx <= f[i];
      repeat (dpc_pkg::BAUD_DIV - 1) @(posedge pclk);
    end
  endtask : send_byte
endmodule : dpc_peer_model
`default_nettype wire

// ---- sim/test_dual_pump_coordinator.sv ----
// testbench: registers, link traffic and sequencing of the pump coordinator
`timescale 1ns/10ps
`default_nettype none
module test_dual_pump_coordinator;
  logic pclk, presetn, psel, penable, pwrite, limit_sw;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q; // q holds prdata of the last transfer
  logic pready, pslverr, link_rx, link_tx, pump_run, pump_dir, e;
  int miscompares, n_compared, cyc;
  dpc_top u_dpc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .limit_sw(limit_sw), .link_rx(link_rx), .link_tx(link_tx),
    .pump_run(pump_run), .pump_dir(pump_dir));
  dpc_peer_model u_dpc_peer_model (.pclk(pclk), .presetn(presetn), .link_tx(link_tx),
    .link_rx(link_rx));
  // ======
  // 40 mhz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ======
  // apb master: setup, access until pready, then an idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic ev(input int b);
    apb(1'b1, dpc_pkg::OFS_EVENT, 32'h0000_0001 << b);
  endtask : ev
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  // bounded wait for the motor enable
  task automatic wait_run(input logic v, input int n);
    repeat (n) if (pump_run !== v) @(posedge pclk);
    chk(32'(pump_run), 32'(v), "pump_run");
  endtask : wait_run
  task automatic seq_is(input dpc_pkg::dpc_seq_t s);
    apb(1'b0, dpc_pkg::OFS_STAT, 32'h0000_0000);
    chk(32'(q[5:3]), 32'(s), "sequence step");
  endtask : seq_is
  // ======
  // scenarios
  task automatic t_regs();
    apb(1'b0, dpc_pkg::OFS_CTRL, 32'h0000_0000);
    chk(q, dpc_pkg::CTRL_RESET, "ctrl reset");
    apb(1'b1, dpc_pkg::OFS_CTRL, 32'h0000_0049);
    apb(1'b0, dpc_pkg::OFS_CTRL, 32'h0000_0000);
    chk(q & 32'h0000_007F, 32'h0000_0049, "ctrl readback");
    apb(1'b1, dpc_pkg::OFS_RATE, 32'h8000_0100);
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk(32'(e), 32'h0000_0001, "unmapped error");
    apb(1'b0, dpc_pkg::OFS_STAT, 32'h0000_0000);
    chk(32'({e, q[6], q[0]}), 32'h0000_0000, "stat reset, link idle");
    apb(1'b1, dpc_pkg::OFS_CTRL, dpc_pkg::CTRL_RESET);
  endtask : t_regs
  // mirror start goes out on the link, partner stop halts us
  task automatic t_link();
    ev(dpc_pkg::EV_START);
    wait_run(1'b1, 8);
    repeat (50000) if (u_dpc_peer_model.n_rx < 2) @(posedge pclk);
    chk(32'(u_dpc_peer_model.rx_b[0]), 32'(dpc_pkg::SEC_ADDR), "address byte");
    chk(32'(u_dpc_peer_model.rx_b[1]), 32'(dpc_pkg::CMD_START), "start cmd");
    chk(32'(u_dpc_peer_model.running), 32'h0000_0001, "partner runs");
    u_dpc_peer_model.send_byte(dpc_pkg::RPT_STOPPED);
    wait_run(1'b0, 4200);
    apb(1'b0, dpc_pkg::OFS_STAT, 32'h0000_0000);
    chk(32'(q[0]), 32'h0000_0001, "peer stop flag");
    apb(1'b1, dpc_pkg::OFS_STAT, 32'h0000_0001);
    apb(1'b0, dpc_pkg::OFS_STAT, 32'h0000_0000);
    chk(32'(q[0]), 32'h0000_0000, "flag cleared");
  endtask : t_link
  task automatic t_stall();
    ev(dpc_pkg::EV_START);
    wait_run(1'b1, 8);
    ev(dpc_pkg::EV_STALL);
    wait_run(1'b0, 8);
    ev(dpc_pkg::EV_START);
    wait_run(1'b1, 8);
    ev(dpc_pkg::EV_STOP);
    wait_run(1'b0, 8);
  endtask : t_stall
  // alternating mode: alt-out is recorded, trigger off clears trigger mode
  task automatic t_alt();
    apb(1'b1, dpc_pkg::OFS_CTRL, 32'h0000_0006);
    ev(dpc_pkg::EV_START);
    ev(dpc_pkg::EV_ALT_OUT);
    apb(1'b0, dpc_pkg::OFS_STAT, 32'h0000_0000);
    chk(32'(q[2:1]), 32'h0000_0003, "alt-out recorded");
    ev(dpc_pkg::EV_TRIG_OFF);
    apb(1'b0, dpc_pkg::OFS_CTRL, 32'h0000_0000);
    chk(q & 32'h0000_007F, 32'h0000_0002, "trigger off");
    ev(dpc_pkg::EV_STOP);
    wait_run(1'b0, 8);
  endtask : t_alt
  // continuous mode, power fail over both prefilled, then pause and resume
  task automatic t_cont();
    apb(1'b1, dpc_pkg::OFS_CTRL, 32'h0000_0077);
    ev(dpc_pkg::EV_START);
    wait_run(1'b1, 8);
    seq_is(dpc_pkg::SEQ_FILL);
    chk(32'(pump_dir), 32'h0000_0001, "filling withdraws");
    limit_sw <= 1'b1;
    repeat (20) if (pump_dir !== 1'b0) @(posedge pclk);
    seq_is(dpc_pkg::SEQ_INFUSE);
    limit_sw <= 1'b0;
    ev(dpc_pkg::EV_STOP);
    wait_run(1'b0, 8);
    seq_is(dpc_pkg::SEQ_HOLD);
    ev(dpc_pkg::EV_START);
    wait_run(1'b1, 8);
    seq_is(dpc_pkg::SEQ_INFUSE);
  endtask : t_cont
  // ======
  // verdict
  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, limit_sw} = 5'b0_0000;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_link();
    t_stall();
    t_alt();
    t_cont();
    final_report();
  end
  // hang guard, well above the longest expected run
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 95000) begin
      miscompares++;
      $display("CHECK FAILED %0t timeout", $time);
      final_report();
    end
  end
endmodule : test_dual_pump_coordinator
`default_nettype wire
